// ==== tmr_defines.svh ====
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ----------------------------------------------------------------
// byte addresses on the cpu port
// ----------------------------------------------------------------
`define TMR_A_CNT_L   4'h0
`define TMR_A_CNT_H   4'h1
`define TMR_A_CMPA_L  4'h2
`define TMR_A_CMPA_H  4'h3
`define TMR_A_CMPB_L  4'h4
`define TMR_A_CMPB_H  4'h5
`define TMR_A_CAP_L   4'h6
`define TMR_A_CAP_H   4'h7
`define TMR_A_CTRL_A  4'h8
`define TMR_A_CTRL_B  4'h9
`define TMR_A_FLAG    4'hA
`define TMR_A_MASK    4'hB

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TMR_CA_MODE_HI 2
`define TMR_CA_COMB_LO 4
`define TMR_CA_COMA_LO 6
`define TMR_CB_CS_HI   2
`define TMR_CB_EDGE    6
`define TMR_CB_NC      7
`define TMR_F_OVF      0
`define TMR_F_CMPA     1
`define TMR_F_CMPB     2
`define TMR_F_CAP      5
`define TMR_F_VALID    8'h27

// ----------------------------------------------------------------
// reset values and count limits
// ----------------------------------------------------------------
`define TMR_RST_16     16'h0000
`define TMR_RST_8      8'h00
`define TMR_BOTTOM     16'h0000
`define TMR_MAX        16'hFFFF
`define TMR_TOP8       16'h00FF
`define TMR_TOP9       16'h01FF
`define TMR_TOP10      16'h03FF

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define TMR_DIV8_M     10'h007
`define TMR_DIV64_M    10'h03F
`define TMR_DIV256_M   10'h0FF
`define TMR_DIV1024_M  10'h3FF
`define TMR_NC_SAMPLES 4

`endif

// ==== tmr_pkg.sv ====
package tmr_pkg;

    typedef enum logic [2:0] {
        TMR_CS_OFF, TMR_CS_DIV1, TMR_CS_DIV8, TMR_CS_DIV64,
        TMR_CS_DIV256, TMR_CS_DIV1024, TMR_CS_EXT_FALL, TMR_CS_EXT_RISE
    } tmr_clk_sel_t;

    typedef enum logic [2:0] {
        TMR_M_NORMAL, TMR_M_PWM8, TMR_M_PWM9, TMR_M_PWM10,
        TMR_M_CTC_CMPA, TMR_M_CTC_CAP, TMR_M_PWM_CAP, TMR_M_PWM_CMPA
    } tmr_mode_t;

endpackage

// ==== tmr_evt_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface tmr_evt_if;
    logic                 tick;
    logic                 cap_evt;
    tmr_pkg::tmr_clk_sel_t clk_sel;
    logic                 cap_rise;
    logic                 nc_en;
    logic                 run_en;

    modport core (input tick, input cap_evt, output clk_sel,
                  output cap_rise, output nc_en, output run_en);
    modport gen  (output tick, output cap_evt, input clk_sel,
                  input cap_rise, input nc_en, input run_en);
endinterface

`default_nettype wire

// ==== tmr_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.svh"

module tmr_tick_gen #(
    parameter int NC_LEN = `TMR_NC_SAMPLES
) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic external_count_pin,
    input  wire logic capture_input_pin,
    input  wire logic comparator_output,
    input  wire logic use_comparator,
    tmr_evt_if.gen    ev
);

    if (NC_LEN < 2 || NC_LEN > 16) begin : g_bad_len
        $error("tmr_tick_gen: NC_LEN must be 2..16");
    end

    function automatic logic div_hit(input logic [9:0] p,
                                     input logic [9:0] m);
        return (p & m) == m;
    endfunction

    logic [2:0]        ext_q,  ext_d;
    logic [1:0]        icp_q,  icp_d;
    logic [1:0]        aco_q,  aco_d;
    logic [NC_LEN-1:0] nc_q,   nc_d;
    logic              lvl_q,  lvl_d;
    logic [9:0]        pre_q,  pre_d;
    logic              tick_q, tick_d;
    logic              cev_q,  cev_d;
    logic              src;

    // ----------------------------------------------------------------
    // clock select and capture filter
    // ----------------------------------------------------------------
    always_comb begin
        ext_d = {ext_q[1:0], external_count_pin};
        icp_d = {icp_q[0], capture_input_pin};
        aco_d = {aco_q[0], comparator_output};
        src   = use_comparator ? aco_q[1] : icp_q[1];
        nc_d  = {nc_q[NC_LEN-2:0], src};
        pre_d = ev.run_en ? pre_q + 10'h001 : 10'h000;
        lvl_d = lvl_q;
        // the filter trades NC_LEN-1 cycles of latency for spike rejection
        if (!ev.nc_en) begin
            lvl_d = src;
        end else if (&nc_d) begin
            lvl_d = 1'b1;
        end else if (~|nc_d) begin
            lvl_d = 1'b0;
        end
        cev_d = ev.run_en && (lvl_d != lvl_q) && (lvl_d == ev.cap_rise);
        unique case (ev.clk_sel)
            tmr_pkg::TMR_CS_OFF:      tick_d = 1'b0;
            tmr_pkg::TMR_CS_DIV1:     tick_d = 1'b1;
            tmr_pkg::TMR_CS_DIV8:     tick_d = div_hit(pre_q, `TMR_DIV8_M);
            tmr_pkg::TMR_CS_DIV64:    tick_d = div_hit(pre_q, `TMR_DIV64_M);
            tmr_pkg::TMR_CS_DIV256:   tick_d = div_hit(pre_q, `TMR_DIV256_M);
            tmr_pkg::TMR_CS_DIV1024:  tick_d = div_hit(pre_q, `TMR_DIV1024_M);
            tmr_pkg::TMR_CS_EXT_FALL: tick_d = ext_q[2] & ~ext_q[1];
            tmr_pkg::TMR_CS_EXT_RISE: tick_d = ~ext_q[2] & ext_q[1];
        endcase
        tick_d = tick_d & ev.run_en;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ext_q  <= 3'h0;
            icp_q  <= 2'h0;
            aco_q  <= 2'h0;
            nc_q   <= '0;
            lvl_q  <= 1'b0;
            pre_q  <= 10'h000;
            tick_q <= 1'b0;
            cev_q  <= 1'b0;
        end else begin
            ext_q  <= ext_d;
            icp_q  <= icp_d;
            aco_q  <= aco_d;
            nc_q   <= nc_d;
            lvl_q  <= lvl_d;
            pre_q  <= pre_d;
            tick_q <= tick_d;
            cev_q  <= cev_d;
        end
    end

    assign ev.tick    = tick_q;
    assign ev.cap_evt = cev_q;

endmodule

`default_nettype wire

// ==== tmr_core.sv ====
// Notes on behaviour
// - one shared latch stages every high byte.
// - low write loads latch and byte together.
// - low read copies high byte to latch; high read returns it.
// - compare reads bypass the latch.
// - tick from prescaler or pin edge; idle if none.
// - compares checked on each counted tick; a match sets its flag.
// - compares drive pwm or frequency outputs.
// - filtered capture pin or comparator edge copies counter unless capture sets top.
// - 0x0000 is bottom, 0xFFFF is max.
// - top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture.
// - compare A as pwm top: no A output, double buffered.
// - four flags, each gated by its mask bit.
// - runs only while the power-off bit is zero.
// - capture flag sets with the copy; ack or one clears.
// - counter write beats count and clear.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.svh"

module tmr_core #(
    parameter int NC_LEN = `TMR_NC_SAMPLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [3:0] cpu_addr,
    input  wire logic       cpu_wr_en,
    input  wire logic       cpu_rd_en,
    input  wire logic [7:0] cpu_wdata,
    output var  logic [7:0] cpu_rdata,
    input  wire logic       timer_power_off_bit,
    input  wire logic [3:0] irq_ack,
    input  wire logic       external_count_pin,
    input  wire logic       capture_input_pin,
    input  wire logic       comparator_output,
    input  wire logic       capture_use_comparator,
    output var  logic [1:0] compare_output_pins,
    output var  logic [3:0] timer_irq_req,
    output var  logic [15:0] count_value
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic is_pwm(input tmr_pkg::tmr_mode_t m);
        return m inside {tmr_pkg::TMR_M_PWM8, tmr_pkg::TMR_M_PWM9,
                         tmr_pkg::TMR_M_PWM10, tmr_pkg::TMR_M_PWM_CAP,
                         tmr_pkg::TMR_M_PWM_CMPA};
    endfunction

    // pwm: 10 sets at wrap and clears at match, 11 inverts, 0x low; else toggle, clear or set
    function automatic logic wave_next(input logic [1:0] com,
                                       input logic pwm, input logic hit,
                                       input logic wrap, input logic cur);
        logic r;
        r = cur;
        if (pwm) begin
            if (com[1] && hit) begin
                r = com[0];
            end else if (com[1] && wrap) begin
                r = ~com[0];
            end else if (!com[1]) begin
                r = 1'b0;
            end
        end else if (hit) begin
            unique case (com)
                2'b00: r = cur;
                2'b01: r = ~cur;
                2'b10: r = 1'b0;
                2'b11: r = 1'b1;
            endcase
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // tick and capture event source
    // ----------------------------------------------------------------
    tmr_evt_if ev ();

    tmr_tick_gen #(.NC_LEN(NC_LEN)) u_tick (
        .ref_clk            (ref_clk),
        .rstn               (rstn),
        .external_count_pin (external_count_pin),
        .capture_input_pin  (capture_input_pin),
        .comparator_output  (comparator_output),
        .use_comparator     (capture_use_comparator),
        .ev                 (ev)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0] cnt_q,   cnt_d;
    logic [15:0] cabuf_q, cabuf_d;
    logic [15:0] cbbuf_q, cbbuf_d;
    logic [15:0] cma_q,   cma_d;
    logic [15:0] cmb_q,   cmb_d;
    logic [15:0] cap_q,   cap_d;
    logic [7:0]  latch_q, latch_d;
    logic [7:0]  ctla_q,  ctla_d;
    logic [7:0]  ctlb_q,  ctlb_d;
    logic [7:0]  flag_q,  flag_d;
    logic [7:0]  mask_q,  mask_d;
    logic [7:0]  rd_q,    rd_d;
    logic [1:0]  oc_q,    oc_d;
    logic [3:0]  irq_q,   irq_d;

    tmr_pkg::tmr_mode_t mode;
    logic        pwm, cap_top, cnt_wr, step, at_top, wrap;
    logic        hit_a, hit_b, ovf, cap_now;
    logic [15:0] top;
    logic [7:0]  set_v, clr_v;

    assign ev.clk_sel  = tmr_pkg::tmr_clk_sel_t'(ctlb_q[`TMR_CB_CS_HI:0]);
    assign ev.cap_rise = ctlb_q[`TMR_CB_EDGE];
    assign ev.nc_en    = ctlb_q[`TMR_CB_NC];
    assign ev.run_en   = ~timer_power_off_bit;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        mode    = tmr_pkg::tmr_mode_t'(ctla_q[`TMR_CA_MODE_HI:0]);
        pwm     = is_pwm(mode);
        cap_top = mode inside {tmr_pkg::TMR_M_CTC_CAP,
                               tmr_pkg::TMR_M_PWM_CAP};
        unique case (mode)
            tmr_pkg::TMR_M_PWM8:     top = `TMR_TOP8;
            tmr_pkg::TMR_M_PWM9:     top = `TMR_TOP9;
            tmr_pkg::TMR_M_PWM10:    top = `TMR_TOP10;
            tmr_pkg::TMR_M_CTC_CMPA: top = cma_q;
            tmr_pkg::TMR_M_PWM_CMPA: top = cma_q;
            tmr_pkg::TMR_M_CTC_CAP:  top = cap_q;
            tmr_pkg::TMR_M_PWM_CAP:  top = cap_q;
            default:                 top = `TMR_MAX;
        endcase
        cnt_wr = cpu_wr_en && cpu_addr == `TMR_A_CNT_L;
        // a cpu counter write also masks this tick's compare match
        step   = ev.tick && !cnt_wr;
        at_top = cnt_q == top;
        wrap   = step && at_top;
        ovf    = step && (pwm ? at_top : cnt_q == `TMR_MAX);
        hit_a  = step && cnt_q == cma_q;
        hit_b  = step && cnt_q == cmb_q;
        cap_now = ev.cap_evt && !cap_top;

        cnt_d   = cnt_q;
        cabuf_d = cabuf_q;
        cbbuf_d = cbbuf_q;
        cap_d   = cap_q;
        latch_d = latch_q;
        ctla_d  = ctla_q;
        ctlb_d  = ctlb_q;
        mask_d  = mask_q;
        rd_d    = rd_q;
        clr_v   = 8'h00;

        if (step) begin
            cnt_d = at_top ? `TMR_BOTTOM : cnt_q + 16'h0001;
        end
        if (cap_now) begin
            cap_d = cnt_q;
        end

        if (cpu_wr_en) begin
            unique case (cpu_addr)
                `TMR_A_CNT_H, `TMR_A_CMPA_H,
                `TMR_A_CMPB_H, `TMR_A_CAP_H: latch_d = cpu_wdata;
                `TMR_A_CNT_L:  cnt_d   = {latch_q, cpu_wdata};
                `TMR_A_CMPA_L: cabuf_d = {latch_q, cpu_wdata};
                `TMR_A_CMPB_L: cbbuf_d = {latch_q, cpu_wdata};
                `TMR_A_CAP_L: begin
                    // capture is writable only while it defines top
                    if (cap_top) begin
                        cap_d = {latch_q, cpu_wdata};
                    end
                end
                `TMR_A_CTRL_A: ctla_d = cpu_wdata;
                `TMR_A_CTRL_B: ctlb_d = cpu_wdata;
                `TMR_A_FLAG:   clr_v  = cpu_wdata;
                `TMR_A_MASK:   mask_d = cpu_wdata & `TMR_F_VALID;
                default: ;
            endcase
        end else if (cpu_rd_en) begin
            unique case (cpu_addr)
                `TMR_A_CNT_L: begin
                    rd_d    = cnt_q[7:0];
                    latch_d = cnt_q[15:8];
                end
                `TMR_A_CAP_L: begin
                    rd_d    = cap_q[7:0];
                    latch_d = cap_q[15:8];
                end
                `TMR_A_CNT_H, `TMR_A_CAP_H: rd_d = latch_q;
                `TMR_A_CMPA_L: rd_d = cabuf_q[7:0];
                `TMR_A_CMPA_H: rd_d = cabuf_q[15:8];
                `TMR_A_CMPB_L: rd_d = cbbuf_q[7:0];
                `TMR_A_CMPB_H: rd_d = cbbuf_q[15:8];
                `TMR_A_CTRL_A: rd_d = ctla_q;
                `TMR_A_CTRL_B: rd_d = ctlb_q;
                `TMR_A_FLAG:   rd_d = flag_q;
                `TMR_A_MASK:   rd_d = mask_q;
                default:       rd_d = 8'h00;
            endcase
        end

        // pwm loads compares at top so no period is cut short
        cma_d = cma_q;
        cmb_d = cmb_q;
        if (!pwm) begin
            cma_d = cabuf_d;
            cmb_d = cbbuf_d;
        end else if (wrap) begin
            cma_d = cabuf_q;
            cmb_d = cbbuf_q;
        end

        oc_d[0] = wave_next(ctla_q[`TMR_CA_COMA_LO+:2], pwm, hit_a, wrap,
                            oc_q[0]);
        if (mode == tmr_pkg::TMR_M_PWM_CMPA) begin
            oc_d[0] = 1'b0;
        end
        oc_d[1] = wave_next(ctla_q[`TMR_CA_COMB_LO+:2], pwm, hit_b, wrap,
                            oc_q[1]);

        set_v = 8'h00;
        set_v[`TMR_F_OVF]  = ovf;
        set_v[`TMR_F_CMPA] = hit_a;
        set_v[`TMR_F_CMPB] = hit_b;
        set_v[`TMR_F_CAP]  = cap_now;
        clr_v[`TMR_F_OVF]  = clr_v[`TMR_F_OVF]  | irq_ack[0];
        clr_v[`TMR_F_CMPA] = clr_v[`TMR_F_CMPA] | irq_ack[1];
        clr_v[`TMR_F_CMPB] = clr_v[`TMR_F_CMPB] | irq_ack[2];
        clr_v[`TMR_F_CAP]  = clr_v[`TMR_F_CAP]  | irq_ack[3];
        // a set in the clearing cycle survives
        flag_d = ((flag_q & ~clr_v) | set_v) & `TMR_F_VALID;

        irq_d = {flag_d[`TMR_F_CAP],  flag_d[`TMR_F_CMPB],
                 flag_d[`TMR_F_CMPA], flag_d[`TMR_F_OVF]}
              & {mask_d[`TMR_F_CAP],  mask_d[`TMR_F_CMPB],
                 mask_d[`TMR_F_CMPA], mask_d[`TMR_F_OVF]};
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_q   <= `TMR_RST_16;
            cabuf_q <= `TMR_RST_16;
            cbbuf_q <= `TMR_RST_16;
            cma_q   <= `TMR_RST_16;
            cmb_q   <= `TMR_RST_16;
            cap_q   <= `TMR_RST_16;
            latch_q <= `TMR_RST_8;
            ctla_q  <= `TMR_RST_8;
            ctlb_q  <= `TMR_RST_8;
            flag_q  <= `TMR_RST_8;
            mask_q  <= `TMR_RST_8;
            rd_q    <= `TMR_RST_8;
            oc_q    <= 2'h0;
            irq_q   <= 4'h0;
        end else begin
            cnt_q   <= cnt_d;
            cabuf_q <= cabuf_d;
            cbbuf_q <= cbbuf_d;
            cma_q   <= cma_d;
            cmb_q   <= cmb_d;
            cap_q   <= cap_d;
            latch_q <= latch_d;
            ctla_q  <= ctla_d;
            ctlb_q  <= ctlb_d;
            flag_q  <= flag_d;
            mask_q  <= mask_d;
            rd_q    <= rd_d;
            oc_q    <= oc_d;
            irq_q   <= irq_d;
        end
    end

    assign cpu_rdata           = rd_q;
    assign compare_output_pins = oc_q;
    assign timer_irq_req       = irq_q;
    assign count_value         = cnt_q;

endmodule

`default_nettype wire

// ==== tmr_core_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module tmr_core_sva (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [3:0]  cpu_addr,
    input wire logic        cpu_wr_en,
    input wire logic        cpu_rd_en,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  cpu_rdata,
    input wire logic        timer_power_off_bit,
    input wire logic [1:0]  compare_output_pins,
    input wire logic [3:0]  timer_irq_req,
    input wire logic [15:0] count_value
);
    // ------------------------------------------------------------
    // shadow of the control bytes the properties depend on
    // ------------------------------------------------------------
    logic [2:0] cs_q;
    logic [2:0] mode_q;
    logic [3:0] mk_q;
    logic [2:0] off_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cs_q   <= 3'h0;
            mode_q <= 3'h0;
            mk_q   <= 4'h0;
            off_q  <= 3'h0;
        end else begin
            if (cpu_wr_en && cpu_addr == 4'h9)
                cs_q <= cpu_wdata[2:0];
            if (cpu_wr_en && cpu_addr == 4'h8)
                mode_q <= cpu_wdata[2:0];
            if (cpu_wr_en && cpu_addr == 4'hB)
                mk_q <= {cpu_wdata[5], cpu_wdata[2:0]};
            // saturating idle count; a tick may still be in flight
            if (cs_q != 3'h0 && !timer_power_off_bit)
                off_q <= 3'h0;
            else if (off_q != 3'h7)
                off_q <= off_q + 3'h1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    property p_rst_vals;
        disable iff (1'b0)
        !rstn |=> count_value == 16'h0000 && cpu_rdata == 8'h00
            && timer_irq_req == 4'h0 && compare_output_pins == 2'h0;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("outputs not cleared by reset");

    property p_wr16;
        cpu_wr_en && cpu_addr == 4'h1 ##1 cpu_wr_en && cpu_addr == 4'h0
        |=> count_value == {$past(cpu_wdata, 2), $past(cpu_wdata)};
    endproperty
    a_wr16: assert property (p_wr16)
        else $error("counter not loaded from latch and low byte");

    property p_rd_lo;
        cpu_rd_en && !cpu_wr_en && cpu_addr == 4'h0
        |=> cpu_rdata == $past(count_value[7:0]);
    endproperty
    a_rd_lo: assert property (p_rd_lo)
        else $error("counter low byte read wrong");

    property p_rd_hi;
        cpu_rd_en && !cpu_wr_en && cpu_addr == 4'h0
        ##1 cpu_rd_en && !cpu_wr_en && cpu_addr == 4'h1
        |=> cpu_rdata == $past(count_value[15:8], 2);
    endproperty
    a_rd_hi: assert property (p_rd_hi)
        else $error("high byte not taken with low read");

    property p_unmap;
        cpu_rd_en && !cpu_wr_en && cpu_addr >= 4'hC |=> cpu_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");

    property p_idle;
        off_q == 3'h7 && !$past(cpu_wr_en) |-> $stable(count_value);
    endproperty
    a_idle: assert property (p_idle)
        else $error("counter moved with no clock source");

    property p_irq_mask;
        (timer_irq_req & ~(mk_q | $past(mk_q))) == 4'h0;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("request raised while masked");

    property p_pin_a;
        mode_q == 3'h7 && $past(mode_q) == 3'h7 |-> !compare_output_pins[0];
    endproperty
    a_pin_a: assert property (p_pin_a)
        else $error("pin A driven while compare A sets top");
endmodule

bind tmr_core tmr_core_sva tmr_core_sva_i (
    .ref_clk(ref_clk), .rstn(rstn), .cpu_addr(cpu_addr),
    .cpu_wr_en(cpu_wr_en), .cpu_rd_en(cpu_rd_en), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .timer_power_off_bit(timer_power_off_bit),
    .compare_output_pins(compare_output_pins),
    .timer_irq_req(timer_irq_req), .count_value(count_value)
);

`default_nettype wire

// ==== tmr_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module tmr_cpu_model (
    input  wire logic       ref_clk,
    output var  logic [3:0] cpu_addr,
    output var  logic       cpu_wr_en,
    output var  logic       cpu_rd_en,
    output var  logic [7:0] cpu_wdata,
    input  wire logic [7:0] cpu_rdata
);
    initial begin
        cpu_addr = 4'h0;
        cpu_wr_en = 1'b0;
        cpu_rd_en = 1'b0;
        cpu_wdata = 8'h00;
    end

    task automatic wr8(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        cpu_wr_en <= 1'b1;
        cpu_addr <= a;
        cpu_wdata <= v;
        @(posedge ref_clk);
        cpu_wr_en <= 1'b0;
        cpu_wdata <= ~v;
    endtask

    task automatic rd8(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        cpu_rd_en <= 1'b1;
        cpu_addr <= a;
        @(posedge ref_clk);
        cpu_rd_en <= 1'b0;
        #1;
        v = cpu_rdata;
    endtask

    // pairs run back to back so nothing disturbs the latch mid-pair
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        cpu_wr_en <= 1'b1;
        cpu_addr <= a | 4'h1;
        cpu_wdata <= v[15:8];
        @(posedge ref_clk);
        cpu_addr <= a;
        cpu_wdata <= v[7:0];
        @(posedge ref_clk);
        cpu_wr_en <= 1'b0;
        cpu_wdata <= ~v[7:0];
    endtask

    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        cpu_rd_en <= 1'b1;
        cpu_addr <= a;
        @(posedge ref_clk);
        cpu_addr <= a | 4'h1;
        #1;
        v[7:0] = cpu_rdata;
        @(posedge ref_clk);
        cpu_rd_en <= 1'b0;
        #1;
        v[15:8] = cpu_rdata;
    endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    wire  [3:0]  addr;
    wire         wr_en;
    wire         rd_en;
    wire  [7:0]  wdata;
    logic [7:0]  rdata;
    logic        pwr_off = 1'b0;
    logic [3:0]  irq_ack = 4'h0;
    logic        ext_pin = 1'b0;
    logic        cap_pin = 1'b0;
    logic [1:0]  pins;
    logic [3:0]  irq;
    logic [15:0] cnt;
    logic [15:0] m [4] = '{default: 16'h0000};
    logic [15:0] tops [4] = '{16'h0, 16'h00FF, 16'h01FF, 16'h03FF};
    logic [15:0] d;
    logic [15:0] c0;
    logic [7:0]  b;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          k;

    always #2 ref_clk = ~ref_clk;

    tmr_cpu_model cpu_i (.ref_clk(ref_clk), .cpu_addr(addr),
        .cpu_wr_en(wr_en), .cpu_rd_en(rd_en), .cpu_wdata(wdata),
        .cpu_rdata(rdata));

    tmr_core #(.NC_LEN(2)) tmr_core_i (.ref_clk(ref_clk), .rstn(rstn),
        .cpu_addr(addr), .cpu_wr_en(wr_en), .cpu_rd_en(rd_en),
        .cpu_wdata(wdata), .cpu_rdata(rdata), .timer_power_off_bit(pwr_off),
        .irq_ack(irq_ack), .external_count_pin(ext_pin),
        .capture_input_pin(cap_pin), .comparator_output(1'b0),
        .capture_use_comparator(1'b0), .compare_output_pins(pins),
        .timer_irq_req(irq), .count_value(cnt));

    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic w16(int i, logic [15:0] v);
        cpu_i.wr16(4'(2 * i), v);
        m[i] = v;
    endtask

    task automatic r16(int i);
        cpu_i.rd16(4'(2 * i), d);
        chk("reg16", d, m[i]);
    endtask

    task automatic ack(int i);
        @(posedge ref_clk);
        irq_ack <= 4'h1 << i;
        @(posedge ref_clk);
        irq_ack <= 4'h0;
        @(negedge ref_clk);
        chk("ack", 16'(irq[i]), 16'h0);
    endtask

    task automatic complete_run();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(27));
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        chk("cnt", cnt, 16'h0);
        for (k = 0; k < 4; k++) r16(k);
        for (k = 0; k < 6; k++) begin
            w16(k % 3, 16'($urandom));
            r16(k % 3);
        end
        cpu_i.rd8(4'h0, b);
        cpu_i.rd8(4'h3, b);
        chk("cmp_hi", 16'(b), 16'(m[1][15:8]));
        cpu_i.rd8(4'h1, b);
        chk("latch", 16'(b), 16'(m[0][15:8]));
        cpu_i.wr8(4'h5, 8'h5A);
        cpu_i.wr8(4'h0, 8'h3C);
        m[0] = 16'h5A3C;
        r16(0);
        cpu_i.wr16(4'h6, 16'hA5C3);
        r16(3);
        cpu_i.rd8(4'hE, b);
        chk("unmapped", 16'(b), 16'h0);
        // overflow and compare A flags
        cpu_i.wr8(4'hB, 8'h27);
        w16(0, 16'hFFF8);
        cpu_i.wr8(4'h9, 8'h01);
        repeat (14) @(negedge ref_clk);
        chk("ovf_irq", 16'(irq[0]), 16'h1);
        cpu_i.wr8(4'h9, 8'h00);
        ack(0);
        w16(1, 16'h0100);
        w16(0, 16'h00F0);
        cpu_i.wr8(4'hA, 8'h27);
        cpu_i.wr8(4'h9, 8'h01);
        repeat (24) @(posedge ref_clk);
        cpu_i.wr8(4'h9, 8'h00);
        cpu_i.rd8(4'hA, b);
        chk("cmpa_flag", 16'(b & 8'h02), 16'h2);
        cpu_i.wr8(4'hA, 8'h02);
        cpu_i.rd8(4'hA, b);
        chk("cmpa_clr", 16'(b & 8'h02), 16'h0);
        // power gating and clock source
        @(posedge ref_clk);
        pwr_off <= 1'b1;
        cpu_i.wr8(4'h9, 8'h01);
        repeat (6) @(negedge ref_clk);
        c0 = cnt;
        repeat (8) @(negedge ref_clk);
        chk("pwr_off", cnt, c0);
        @(posedge ref_clk) pwr_off <= 1'b0;
        repeat (8) @(negedge ref_clk);
        chk("running", 16'(cnt != c0), 16'h1);
        cpu_i.wr8(4'h9, 8'h07);
        repeat (2) @(negedge ref_clk);
        c0 = cnt;
        for (k = 0; k < 6; k++) begin
            @(posedge ref_clk);
            ext_pin <= ~ext_pin;
            repeat (4) @(posedge ref_clk);
        end
        repeat (6) @(negedge ref_clk);
        chk("ext_cnt", cnt - c0, 16'h3);
        for (k = 1; k < 4; k++) begin
            cpu_i.wr8(4'h9, 8'h00);
            cpu_i.wr8(4'h8, 8'(k));
            w16(0, tops[k] - 16'h3);
            cpu_i.wr8(4'h9, 8'h01);
            repeat (10) @(negedge ref_clk);
            chk("wrap_top", 16'(cnt < 16'h0010), 16'h1);
        end
        // pwm on B; A silent when it sets top
        cpu_i.wr8(4'h8, 8'h00);
        w16(2, 16'h0080);
        w16(0, 16'h0);
        cpu_i.wr8(4'h8, 8'h21);
        for (k = 0; k < 300 && cnt != 16'h00C0; k++) @(negedge ref_clk);
        chk("pwm_lo", 16'(pins[1]), 16'h0);
        for (k = 0; k < 300 && cnt != 16'h0040; k++) @(negedge ref_clk);
        chk("pwm_hi", 16'(pins[1]), 16'h1);
        cpu_i.wr8(4'h8, 8'hC7);
        repeat (10) @(negedge ref_clk);
        chk("pin_a", 16'(pins[0]), 16'h0);
        // filtered capture; one-cycle spike dropped
        cpu_i.wr8(4'h8, 8'h00);
        cpu_i.wr8(4'hA, 8'h27);
        cpu_i.wr8(4'h9, 8'hC1);
        @(negedge ref_clk);
        c0 = cnt;
        @(posedge ref_clk);
        cap_pin <= 1'b1;
        for (k = 0; k < 20 && irq[3] !== 1'b1; k++) @(negedge ref_clk);
        chk("cap_irq", 16'(irq[3]), 16'h1);
        cpu_i.wr8(4'h9, 8'h00);
        cpu_i.rd16(4'h6, d);
        chk("cap_val", 16'(d - c0 < 16'd14 && d != c0), 16'h1);
        ack(3);
        @(posedge ref_clk) cap_pin <= 1'b0;
        cpu_i.wr8(4'h9, 8'hC1);
        repeat (10) @(posedge ref_clk);
        cap_pin <= 1'b1;
        @(posedge ref_clk);
        cap_pin <= 1'b0;
        repeat (12) @(negedge ref_clk);
        chk("spike", 16'(irq[3]), 16'h0);
        complete_run();
    end
endmodule

`default_nettype wire
